// >>> src/srq_poll_pkg.sv
// constants for the service-request / control-mode block
// shared by the main module, its flag timer helper and the bench
package srq_poll_pkg;
  // register byte offsets on the avalon slave
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_GATE    = 4'h4;
  localparam logic [3:0] OFS_STATUS  = 4'h8;
  localparam logic [3:0] OFS_RETURN  = 4'hC;
  // control field positions
  localparam int BIT_OUT_SYS_EN  = 0;
  localparam int BIT_GATE_EN     = 1;
  localparam int BIT_TIMED       = 2;
  localparam int BIT_IN_SEL      = 3;
  localparam int BIT_CARD_IRQ_EN = 4;
  localparam logic [4:0] CONTROL_RST = 5'h00;
  // status byte values
  localparam logic [7:0] POLL_SRQ  = 8'h40;
  localparam logic [7:0] POLL_IDLE = 8'h00;
  // data field width (four octal digits)
  localparam int DATA_W = 12;
  // timing: d/a flag time
  localparam int CLK_HZ     = 20000000;
  localparam int DA_FLAG_NS = 30000;
  localparam int DA_FLAG_CYC = (DA_FLAG_NS / 1000) * (CLK_HZ / 1000000);
  // flag status bits
  localparam int BIT_SRQ  = 0;
  localparam int BIT_BUSY = 1;
  localparam int BIT_IRQ  = 2;
  localparam int BIT_SPM  = 3;
endpackage

// >>> src/pin_sync.sv
// two-flop synchroniser for pin inputs
// assumes a single clock domain on the far side
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] stage1_ff;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_ff <= '0;
      pinOut    <= '0;
    end
    else
    begin
      stage1_ff <= pinIn;
      pinOut    <= stage1_ff;
    end
  end
endmodule

// >>> src/flag_timer.sv
// one-shot cycle timer for the internally timed card flag
// start pulse loads, done pulses once when the count runs out
`timescale 1ns/1ps
module flag_timer #(
  parameter int CYCLES = srq_poll_pkg::DA_FLAG_CYC
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  logic [15:0] count_ff;

  // count down, done as the count steps from one to zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_ff <= 16'h0000;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
        count_ff <= 16'(CYCLES);
      else if (count_ff != 16'h0000)
      begin
        count_ff <= count_ff - 16'h0001;
        if (count_ff == 16'h0001)
          done <= 1'b1;
      end
    end
  end

  assign busy = (count_ff != 16'h0000);
endmodule

// >>> src/service_request_poll_control.sv
// service request, serial poll and control-mode core
// avalon-mm slave toward software; card flag lines arrive as pins
// Behaviour
// R1: raise service request on flag completion, only with timed handshake mode on
// R2: serial poll status byte is 64 when service was requested, else 0
// R3: completing a serial poll clears the pending service request
// R4: poll sequence: enter serial poll mode, talk, transfer status byte; here the byte goes out in the mode step, before talk
// R5: controller detects request by interrupt or status check, then polls
// R6: controller should poll once at start to clear request line
// R7: card timing flag ignored unless timed handshake mode is on
// R8: controller must not gate flagless cards while timed mode is on
// R9: output cards steered by system enable, gate enable, timed mode bits
// R10: output data field is octal 0000 through 7777
// R11: input card readback needs input select mode on in control word
// R12: d/a card returns its flag about 30 us after gating in timed mode
// R13: interrupt input card does gate/flag transfer with external device
// R14: external-flag cards end their flag when the external flag ends
// R15: return word reports input request 1 when flag returned, data valid
// R16: sticky request flag set on completion, cleared only by poll read
`timescale 1ns/1ps
module service_request_poll_control #(
  parameter int DA_CYCLES = srq_poll_pkg::DA_FLAG_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        extFlag,
  input  wire logic [11:0] inputData,
  output logic             serviceRequest,
  output logic             outputSystemEnable,
  output logic             transferGateEnable,
  output logic             cardGate,
  output logic      [11:0] outputData,
  output logic             inputGate
);
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_MODE = 2'b01,
    SP_TALK = 2'b11
  } poll_e;

  logic [4:0]  control_ff;
  logic        srq_ff;
  logic        extBusy_ff;
  logic        irq_ff;
  logic [11:0] inData_ff;
  logic [11:0] outData_ff;
  logic        gatePend_ff;
  logic        extPrev_ff;
  logic        ack_ff;
  poll_e       poll_ff;
  logic        extFlagSync;
  logic        daStart;
  logic        daBusy;
  logic        daDone;
  logic        extDone;
  logic        flagDone;
  logic        wrCtl;
  logic        wrGate;
  logic        rdStatus;
  logic        rdReturn;
  logic        access;
  logic        timed;
  logic        inSel;
  logic        extCard_ff;
  logic [11:0] inDataSync;
  logic        pollStart;

  // window around the nominal d/a flag; the timer answers one edge late, since loading its count takes an edge
  localparam int DA_LO = DA_CYCLES - 1;
  localparam int DA_HI = DA_CYCLES + 2;

  // pin input crosses two flops before use
  pin_sync #(
    .W(1)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .pinIn (extFlag),
    .pinOut(extFlagSync)
  );

  // card data pins are asynchronous too; the card holds them past its flag
  pin_sync #(
    .W(12)
  ) u_syncData (
    .clock (clock),
    .rst_n (rst_n),
    .pinIn (inputData),
    .pinOut(inDataSync)
  );

  // internally timed d/a flag
  flag_timer #(
    .CYCLES(DA_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(daStart),
    .busy (daBusy),
    .done (daDone)
  );

  // one wait cycle per access keeps the slave simple
  assign access      = (read || write) && !ack_ff;
  assign waitrequest = (read || write) && !ack_ff;
  assign wrCtl    = write && ack_ff && (address == srq_poll_pkg::OFS_CONTROL);
  assign wrGate   = write && ack_ff && (address == srq_poll_pkg::OFS_GATE);
  // status byte counts as transferred only in the mode step of a poll, the answering cycle
  assign pollStart = read && !ack_ff && (address == srq_poll_pkg::OFS_STATUS);
  assign rdStatus  = read && ack_ff && (address == srq_poll_pkg::OFS_STATUS) && (poll_ff == SP_MODE); // R4
  assign rdReturn = read && ack_ff && (address == srq_poll_pkg::OFS_RETURN);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= access;
  end

  assign timed = control_ff[srq_poll_pkg::BIT_TIMED];
  assign inSel = control_ff[srq_poll_pkg::BIT_IN_SEL];

  // control word
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      control_ff <= srq_poll_pkg::CONTROL_RST;
    else if (wrCtl)
      control_ff <= writedata[4:0]; // R9
  end

  assign outputSystemEnable = control_ff[srq_poll_pkg::BIT_OUT_SYS_EN]; // R9
  assign transferGateEnable = control_ff[srq_poll_pkg::BIT_GATE_EN];    // R9

  // gated data word; data field masked to four octal digits
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      outData_ff <= 12'h000;
    else if (wrGate && !inSel)
      outData_ff <= writedata[11:0]; // R10
  end
  assign outputData = outData_ff;

  // gate held pending until gate enable allows it out
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      gatePend_ff <= 1'b0;
    else if (wrGate && !inSel)
      gatePend_ff <= 1'b1;
    else if (transferGateEnable)
      gatePend_ff <= 1'b0;
  end

  // card kind kept with the word: bus data is not valid once the write is over
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      extCard_ff <= 1'b0;
    else if (wrGate && !inSel)
      extCard_ff <= writedata[12]; // R14
  end

  assign cardGate = gatePend_ff && transferGateEnable; // R9
  assign daStart  = cardGate && timed && !extCard_ff; // R12
  assign inputGate = wrGate && inSel; // R11

  // external flag: leading edge starts, trailing edge completes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extPrev_ff <= 1'b0;
      extBusy_ff <= 1'b0;
    end
    else
    begin
      extPrev_ff <= extFlagSync;
      if (extFlagSync && !extPrev_ff && timed)
        extBusy_ff <= 1'b1; // R13
      else if (!extFlagSync && extPrev_ff)
        extBusy_ff <= 1'b0; // R14
    end
  end

  assign extDone  = extBusy_ff && !extFlagSync && extPrev_ff; // R14
  assign flagDone = timed && (daDone || extDone); // R7 R1

  // input data latched at flag completion, input request bit kept
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inData_ff <= 12'h000;
      irq_ff    <= 1'b0;
    end
    else if (extDone && timed && inSel)
    begin
      inData_ff <= inDataSync;
      irq_ff    <= 1'b1; // R15 R13
    end
    else if (rdReturn)
      irq_ff <= 1'b0;
  end

  // serial poll sequence: mode, then talk on status read
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      poll_ff <= SP_IDLE;
    else
    begin
      case (poll_ff)
        SP_IDLE: if (pollStart) poll_ff <= SP_MODE; // R4
        SP_MODE: poll_ff <= SP_TALK; // R4
        SP_TALK: poll_ff <= pollStart ? SP_MODE : SP_IDLE; // back-to-back polls allowed
        default: poll_ff <= SP_IDLE;
      endcase
    end
  end

  // sticky request; a completion in the poll cycle wins over the clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      srq_ff <= 1'b0;
    else if (flagDone)
      srq_ff <= 1'b1; // R1 R16
    else if (rdStatus && (readdata[7:0] == srq_poll_pkg::POLL_SRQ))
      srq_ff <= 1'b0; // R3 R16
  end
  assign serviceRequest = srq_ff; // R1

  // read data registered at the answering edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      readdata <= 32'h00000000;
    else if (read && !ack_ff)
    begin
      case (address)
        srq_poll_pkg::OFS_CONTROL: readdata <= {27'h0000000, control_ff};
        srq_poll_pkg::OFS_GATE:    readdata <= {20'h00000, outData_ff};
        srq_poll_pkg::OFS_STATUS:  readdata <= {24'h000000, srq_ff ? srq_poll_pkg::POLL_SRQ
                                                                   : srq_poll_pkg::POLL_IDLE}; // R2
        srq_poll_pkg::OFS_RETURN:  readdata <= inSel ? {19'h00000, irq_ff, inData_ff}
                                                     : 32'h00000000; // R11 R15
        default:                   readdata <= 32'h00000000;
      endcase
    end
  end

  // status byte matches request flag when read
  AST_POLL_VALUE: assert property (@(posedge clock) disable iff (!rst_n) // R2
    rdStatus |-> (readdata[7:0] == ($past(srq_ff) ? 8'h40 : 8'h00)))
    else $error("poll byte mismatch");

  // completed poll clears the reported request absent new completion
  AST_POLL_CLEAR: assert property (@(posedge clock) disable iff (!rst_n) // R3
    (rdStatus && !flagDone && readdata[7:0] == 8'h40) |=> !serviceRequest)
    else $error("poll did not clear request");

  // a request raised after the byte was captured is not lost by that poll
  AST_POLL_KEEP: assert property (@(posedge clock) disable iff (!rst_n) // R16
    (rdStatus && serviceRequest && readdata[7:0] == 8'h00) |=> serviceRequest)
    else $error("unreported request cleared");

  sequence s_pollReq; pollStart; endsequence
  sequence s_pollTalk; ##1 (poll_ff == SP_MODE) ##1 (poll_ff == SP_TALK); endsequence
  // poll walks mode then talk
  AST_POLL_SEQ: assert property (@(posedge clock) disable iff (!rst_n) // R4
    s_pollReq |-> s_pollTalk)
    else $error("poll sequence out of order");

  // an external flag is only tracked in timed mode
  AST_EXT_TIMED: assert property (@(posedge clock) disable iff (!rst_n) // R7
    $rose(extBusy_ff) |-> $past(timed))
    else $error("external flag tracked without timed mode");

  // input request set when the input card flag completes
  AST_IRQ_SET: assert property (@(posedge clock) disable iff (!rst_n) // R15
    (extDone && timed && inSel) |=> irq_ff)
    else $error("input request not set");

  // gate word in input mode leaves the output data alone
  AST_DATA_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // R11
    (wrGate && inSel) |=> $stable(outputData))
    else $error("output data changed in input mode");

  // no request ever raised without timed mode
  AST_TIMED_ONLY: assert property (@(posedge clock) disable iff (!rst_n) // R7
    ($rose(serviceRequest)) |-> $past(timed))
    else $error("request without timed mode");

  // completion raises request next cycle
  AST_SET: assert property (@(posedge clock) disable iff (!rst_n) // R1
    flagDone |=> serviceRequest)
    else $error("request not raised");

  // request is sticky until a poll read
  AST_STICKY: assert property (@(posedge clock) disable iff (!rst_n) // R16
    (serviceRequest && !rdStatus) |=> serviceRequest)
    else $error("request dropped without poll");

  sequence s_gate; cardGate && timed && !extCard_ff; endsequence
  sequence s_flag; ##[DA_LO:DA_HI] daDone; endsequence
  // d/a flag returns about 30 us after gate
  AST_DA_TIME: assert property (@(posedge clock) disable iff (!rst_n) // R12
    s_gate |-> s_flag)
    else $error("d/a flag timing wrong");

  // a gate word leaves at once with gate enable, else it is held
  AST_GATE_EN: assert property (@(posedge clock) disable iff (!rst_n) // R9
    (wrGate && !inSel) |=> (cardGate == transferGateEnable))
    else $error("gate not steered by enable");

  // return data hidden without input select
  AST_INPUT_SELECT: assert property (@(posedge clock) disable iff (!rst_n) // R11
    (rdReturn && !$past(inSel)) |-> (readdata == 32'h00000000))
    else $error("readback without input select");
endmodule

// >>> verif/card_model.sv
// behavioural plug-in card on the far side of the pins
// assumes gates are levels or pulses launched at the rising edge
`timescale 1ns/1ps
module card_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        gateIn,
  input  wire logic [15:0] flagLen,
  input  wire logic [11:0] cardData,
  output logic             extFlag,
  output logic      [11:0] inputData
);
  logic        gateDly_ff;
  logic [15:0] flagCnt_ff;
  logic [2:0]  holdCnt_ff;

  // flag length is set by the external device, not by a fixed time
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gateDly_ff <= 1'b0;
      flagCnt_ff <= 16'h0;
      holdCnt_ff <= 3'h0;
    end
    else
    begin
      gateDly_ff <= gateIn;
      if (gateIn && !gateDly_ff)
        flagCnt_ff <= flagLen;
      else if (flagCnt_ff != 16'h0)
        flagCnt_ff <= flagCnt_ff - 16'h1;
      if (flagCnt_ff != 16'h0)
        holdCnt_ff <= 3'h7;
      else if (holdCnt_ff != 3'h0)
        holdCnt_ff <= holdCnt_ff - 3'h1;
    end
  end

  // data held a few cycles past the flag, since the pins pass a synchroniser
  assign extFlag   = (flagCnt_ff != 16'h0);
  assign inputData = (holdCnt_ff != 3'h0) ? cardData : ~cardData; // stale data never passes
endmodule

// >>> verif/tb.sv
// self-checking bench for the service request and poll core
// assumes the card model file is compiled before this one
`timescale 1ns/1ps
module tb;
  localparam int DA = 20;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        extFlag;
  logic [11:0] inputData;
  logic        serviceRequest;
  logic        outputSystemEnable;
  logic        transferGateEnable;
  logic        cardGate;
  logic [11:0] outputData;
  logic        inputGate;
  logic [15:0] flagLen = 16'h0;
  logic [11:0] cardData = 12'hAAA;
  logic [31:0] rdv;
  int          failCount = 0;
  int          checks = 0;
  int          n;

  always #25 clock = ~clock;

  service_request_poll_control #(.DA_CYCLES(DA)) u_service_request_poll_control (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .extFlag(extFlag),
    .inputData(inputData), .serviceRequest(serviceRequest), .outputSystemEnable(outputSystemEnable),
    .transferGateEnable(transferGateEnable), .cardGate(cardGate), .outputData(outputData),
    .inputGate(inputGate));

  card_model u_card_model (
    .clock(clock), .rst_n(rst_n), .gateIn(cardGate | inputGate), .flagLen(flagLen),
    .cardData(cardData), .extFlag(extFlag), .inputData(inputData));

  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clock);
    read <= rd;
    write <= !rd;
    address <= a;
    writedata <= wd;
    @(posedge clock);
    while (waitrequest !== 1'b0 && k < 20)
    begin
      @(posedge clock);
      k++;
    end
    if (k == 20)
    begin
      failCount++;
      giveVerdict();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(negedge clock); // callers look at outputs once they have settled
  endtask

  task automatic poll(input logic [7:0] exp);
    bus(1'b1, srq_poll_pkg::OFS_STATUS, 32'h0, rdv);
    checkVal(rdv, {24'h0, exp});
  endtask

  // bounded wait for the request line, cycles counted in n
  task automatic waitSrq(input int lim);
    n = 0;
    while (serviceRequest !== 1'b1 && n < lim)
    begin
      @(negedge clock);
      n++;
    end
    if (serviceRequest !== 1'b1)
    begin
      failCount++;
      giveVerdict();
    end
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    checkVal(serviceRequest, 32'h0);
    rst_n <= 1'b1;
    poll(srq_poll_pkg::POLL_IDLE);
    bus(1'b1, srq_poll_pkg::OFS_CONTROL, 32'h0, rdv);
    checkVal(rdv, 32'h0);
    bus(1'b1, 4'h2, 32'h0, rdv);
    checkVal(rdv, 32'h0);
    // timed mode off: the card flag must not raise a request
    flagLen <= 16'd10;
    bus(1'b0, srq_poll_pkg::OFS_CONTROL, 32'h3, rdv);
    checkVal({outputSystemEnable, transferGateEnable}, 32'h3);
    bus(1'b0, srq_poll_pkg::OFS_GATE, 32'hFFF, rdv);
    checkVal(outputData, 32'hFFF);
    repeat (DA + 10) @(negedge clock);
    checkVal(serviceRequest, 32'h0);
    poll(srq_poll_pkg::POLL_IDLE);
    // gate held while transfer gate is off, then released by the control word
    flagLen <= 16'h0;
    bus(1'b0, srq_poll_pkg::OFS_CONTROL, 32'h5, rdv);
    bus(1'b0, srq_poll_pkg::OFS_GATE, 32'h123, rdv);
    checkVal({cardGate, transferGateEnable}, 32'h0);
    bus(1'b0, srq_poll_pkg::OFS_CONTROL, 32'h7, rdv);
    checkVal(cardGate, 32'h1);
    waitSrq(DA + 20);
    checkVal({n >= DA - 4, n <= DA + 4, serviceRequest}, 32'h7);
    repeat (10) @(negedge clock);
    checkVal(serviceRequest, 32'h1);
    poll(srq_poll_pkg::POLL_SRQ);
    checkVal(serviceRequest, 32'h0);
    poll(srq_poll_pkg::POLL_IDLE);
    // external-flag output card: request follows the far device's flag
    flagLen <= 16'd60;
    bus(1'b0, srq_poll_pkg::OFS_GATE, 32'h129C, rdv);
    waitSrq(200);
    checkVal({n >= 55, serviceRequest}, 32'h3);
    poll(srq_poll_pkg::POLL_SRQ);
    // input card in timed mode: gate/flag transfer, then readback
    flagLen <= 16'd30;
    bus(1'b0, srq_poll_pkg::OFS_CONTROL, 32'h1C, rdv);
    bus(1'b0, srq_poll_pkg::OFS_GATE, 32'h1000, rdv);
    waitSrq(200);
    checkVal({n >= 25, serviceRequest}, 32'h3);
    repeat (8) @(negedge clock);
    bus(1'b1, srq_poll_pkg::OFS_RETURN, 32'h0, rdv);
    checkVal(rdv, 32'h1AAA);
    poll(srq_poll_pkg::POLL_SRQ);
    checkVal(serviceRequest, 32'h0);
    giveVerdict();
  end
endmodule
